/* File: bench/psq_far_model.sv */
module psq_far_model
   import psq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pat_advance,
   input wire logic pat_rewind,
   input wire logic [15:0] pat_words,
   input wire logic gate_cmd,
   output logic [15:0] word_a,
   output logic [15:0] word_b,
   output logic gate_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] idx_q, cur;
   // rewind takes effect in the same cycle, so the consumed word is word zero
   assign cur = pat_rewind ? 16'h0000 : idx_q;
   assign word_a = {~cur[7:0], cur[7:0]};
   assign word_b = {cur[7:0], cur[7:0] ^ 8'h5a};
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         idx_q <= 16'h0000;
         gate_in <= 1'b0;
      end else begin
         if (pat_advance) begin
            idx_q <= (cur + 16'h0001 == pat_words) ? 16'h0000 : cur + 16'h0001;
         end
         gate_in <= gate_cmd;
      end
   end
endmodule

/* File: bench/psq_sequencer_asserts.sv */
module psq_sequencer_asserts
   import psq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_apply,
   input wire logic cfg_combined,
   input wire logic cfg_burst_mode,
   input wire logic [1:0] cfg_source,
   input wire logic [1:0] cfg_burst_seq,
   input wire logic [2:0] cfg_pattern_kind,
   input wire logic cfg_gating_out_en,
   input wire logic cfg_precode_en,
   input wire logic gate_in,
   input wire logic [15:0] first_data_channel_word,
   input wire logic pat_advance,
   input wire logic [15:0] data_out_a,
   input wire logic [15:0] data_out_b,
   input wire logic data_valid,
   input wire logic gating_out,
   input wire logic cfg_busy,
   input wire logic burst_refused
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cfgd_q, burst_q, comb_q, pre_q, gen_q, run, eff_burst;
   logic [1:0] src_q, seq_q;
   logic [2:0] kind_q;
   logic [10:0] busy_n_q;
   logic [3:0] low_n_q;
   assign run = cfgd_q && !cfg_busy;
   assign eff_burst = burst_q && !kind_q[2];
   // ----------------------------------------------------------------
   // shadow of the accepted setting set
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfgd_q <= 1'b0;
         busy_n_q <= 11'h000;
         low_n_q <= 4'h0;
      end else begin
         if (cfg_apply && !cfg_busy) begin
            cfgd_q <= 1'b1;
            burst_q <= cfg_burst_mode;
            comb_q <= cfg_combined;
            pre_q <= cfg_precode_en;
            gen_q <= cfg_gating_out_en;
            src_q <= cfg_source;
            seq_q <= cfg_burst_seq;
            kind_q <= cfg_pattern_kind;
         end
         busy_n_q <= cfg_busy ? busy_n_q + 11'h001 : 11'h000;
         // saturates so a long low gate never wraps back into range
         low_n_q <= gate_in ? 4'h0 : (low_n_q == 4'hf ? low_n_q : low_n_q + 4'h1);
      end
   end
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   busy_rise_a: assert property (cfg_apply && !cfg_busy |=> cfg_busy)
      else $error("busy did not follow an accepted setting");
   busy_bound_a: assert property (busy_n_q < 11'h44c)
      else $error("setting processing took too long");
   rst_clear_a: assert property ($fell(rst) |-> !data_valid && !gating_out && !pat_advance)
      else $error("outputs active right after reset");
   zero_idle_a: assert property (!data_valid |-> data_out_a == 16'h0000 && data_out_b == 16'h0000)
      else $error("data not masked while invalid");
   repeat_run_a: assert property (run && !eff_burst |-> pat_advance)
      else $error("repeat pattern interrupted");
   cont_adv_a: assert property (run && eff_burst && seq_q == SEQ_CONTINUOUS |-> pat_advance)
      else $error("continuous sequencing stalled the pattern");
   pass_data_a: assert property (run && !eff_burst && pat_advance && !cfg_apply && !(comb_q && pre_q)
      |=> data_valid && data_out_a[7:0] == $past(first_data_channel_word[7:0]))
      else $error("repeat word not passed through");
   enable_gate_a: assert property (run && eff_burst && src_q == SRC_EXT_ENABLE
      && low_n_q > 4'h6 |-> !data_valid)
      else $error("burst data while gate input low");
   refuse_a: assert property (run && $past(run) |-> burst_refused == (burst_q && kind_q[2]))
      else $error("refusal flag disagrees with pattern kind");
   gate_off_a: assert property (cfgd_q && !gen_q |-> !gating_out)
      else $error("gating output active while disabled");
endmodule

/* File: bench/psq_sequencer_tb.sv */
module psq_sequencer_tb
   import psq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst = 1, cfg_apply = 0, cfg_combined = 0, cfg_burst_mode = 0;
   logic cfg_gating_out_en = 1, cfg_precode_en = 0, precode_init = 0, gate_cmd = 0;
   logic [1:0] cfg_source = 0, cfg_burst_seq = 0;
   logic [2:0] cfg_pattern_kind = 0;
   logic [39:0] cfg_pattern_len = 0, cfg_gate_width = 0, cfg_gate_delay = 0;
   logic [39:0] cfg_trig_delay = 40'h00_0000_0010, cfg_trig_width = 40'h00_0000_0040;
   logic [15:0] pat_words = 16'h0001, word_a, word_b, data_out_a, data_out_b;
   logic gate_in, pat_advance, pat_rewind, data_valid, gating_out, cfg_busy, burst_refused;
   logic [7:0] w0, w1;
   logic [31:0] r = 32'h4a81_2941;
   int failures = 0, cmp_count = 0, cyc = 0, i, k, w, d, hi, per, c;
   always #4 ref_clk = ~ref_clk;
   psq_sequencer u_psq_sequencer (.ref_clk, .rst, .cfg_apply, .cfg_combined, .cfg_burst_mode,
      .cfg_source, .cfg_burst_seq, .cfg_pattern_kind, .cfg_pattern_len,
      .cfg_row_len(16'h0040), .cfg_row_count(16'h0004), .cfg_block_count(8'h02),
      .cfg_gate_width, .cfg_gate_delay, .cfg_enabled_period(40'h00_0000_3200),
      .cfg_burst_cycle(40'h00_0000_6400), .cfg_trig_delay, .cfg_trig_width,
      .cfg_gating_out_en, .cfg_precode_en, .precode_init,
      .gate_in, .first_data_channel_word(word_a), .second_data_channel_word(word_b),
      .pat_advance, .pat_rewind, .data_out_a, .data_out_b, .data_valid, .gating_out,
      .cfg_busy, .burst_refused);
   psq_far_model u_psq_far_model (.ref_clk, .rst, .pat_advance, .pat_rewind, .pat_words,
      .gate_cmd, .word_a, .word_b, .gate_in);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] pc(input logic [15:0] a, b, input logic ip, qp);
      logic [15:0] oa, ob;
      for (int j = 0; j < 16; j++) begin
         oa[j] = (a[j] ^ b[j]) ? b[j] ^ qp : a[j] ^ ip;
         ob[j] = (a[j] ^ b[j]) ? a[j] ^ ip : b[j] ^ qp;
         ip = oa[j];
         qp = ob[j];
      end
      return {oa, ob};
   endfunction
   function automatic logic sig(input logic v);
      return v ? data_valid : gating_out;
   endfunction
   task automatic chk(input string n, input logic [39:0] e, s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cfg(input logic b, cm, pr, input logic [1:0] src, sq, input logic [2:0] kd,
                      input logic [39:0] len, gw, gd);
      int n;
      @(posedge ref_clk);
      {cfg_burst_mode, cfg_combined, cfg_precode_en} <= {b, cm, pr};
      {cfg_source, cfg_burst_seq, cfg_pattern_kind} <= {src, sq, kd};
      {cfg_pattern_len, cfg_gate_width, cfg_gate_delay} <= {len, gw, gd};
      pat_words <= cm ? len[19:4] : len[18:3];
      cfg_apply <= 1'b1;
      @(posedge ref_clk) cfg_apply <= 1'b0;
      @(negedge ref_clk);
      chk("busy", 1, cfg_busy);
      for (n = 0; n < 1200 && cfg_busy !== 1'b0; n++) @(negedge ref_clk);
      chk("busy_end", 0, cfg_busy);
   endtask
   // hi: cycles high from a rising edge, per: cycles to the next rising edge
   task automatic meas(input logic v);
      int n;
      n = 0;
      while (sig(v) !== 1'b0 && n < 9000) begin @(negedge ref_clk); n++; end
      while (sig(v) !== 1'b1 && n < 9000) begin @(negedge ref_clk); n++; end
      w0 = data_out_a[7:0];
      for (hi = 0; sig(v) === 1'b1 && n < 9000; hi++) begin @(negedge ref_clk); n++; end
      for (per = hi; sig(v) !== 1'b1 && n < 9000; per++) begin @(negedge ref_clk); n++; end
      w1 = data_out_a[7:0];
   endtask
   task automatic gwin(input int h, win);
      c = 0;
      for (int j = 0; j < win; j++) begin
         @(posedge ref_clk) gate_cmd <= (j < h);
         @(negedge ref_clk);
         if (data_valid === 1'b1) c++;
      end
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         summarize();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      cfg(0, 0, 1, SRC_INTERNAL, SEQ_RESTART, PAT_PRBS, 40'h00_0000_0400, 40'h00_0000_0200,
          40'h00_0000_0100);
      meas(0);
      chk("gate_hi", 64, hi);
      chk("gate_per", 128, per);
      chk("gate_pos", 32, w0);
      for (i = 0; i < 4; i++) begin
         r = lfsr(r);
         k = r % 97;
         w = 128 + 8 * k;
         d = 128 + 8 * ((r >> 8) % (97 - k));
         // sub-step bits must be dropped by the step rounding
         cfg(0, 0, 0, SRC_INTERNAL, SEQ_RESTART, PAT_USER_DATA, 40'h00_0000_0400,
             w + r[18:16], d + r[22:20]);
         meas(0);
         chk("gate_hi", w / 8, hi);
         chk("gate_pos", d / 8, w0);
      end
      cfg(0, 1, 0, SRC_INTERNAL, SEQ_RESTART, PAT_PRBS, 40'h00_0000_0400, 40'h00_0000_00c8,
          40'h00_0000_012c);
      meas(0);
      chk("gate_hi", 16, hi);
      chk("gate_pos", 18, w0);
      chk("gate_per", 64, per);
      cfg(0, 0, 0, SRC_INTERNAL, SEQ_RESTART, PAT_PRBS, 40'h00_0000_0064, 40'h00_0000_0080,
          40'h00_0000_0080);
      meas(0);
      chk("gate_per", 1200, per);
      cfg(0, 1, 0, SRC_INTERNAL, SEQ_RESTART, PAT_ZERO_RUN, 40'h00_0000_012c, 40'h00_0000_0100,
          40'h00_0000_0100);
      meas(0);
      chk("gate_per", 1200, per);
      cfg(0, 0, 0, SRC_INTERNAL, SEQ_RESTART, PAT_BLOCK_SEQ, 40'h00_0000_0400, 40'h00_0000_0080,
          40'h00_0000_0080);
      meas(0);
      chk("gate_per", 64, per);
      chk("gate_hi", 16, hi);
      cfg(0, 1, 1, SRC_INTERNAL, SEQ_RESTART, PAT_PRBS, 40'h00_0000_0400, 40'h00_0000_0100,
          40'h00_0000_0100);
      @(posedge ref_clk) precode_init <= 1'b1;
      @(posedge ref_clk) precode_init <= 1'b0;
      @(negedge ref_clk);
      for (i = 0; i < 16; i++) begin
         r = pc(word_a, word_b, i == 0 || data_out_a[15], i == 0 || data_out_b[15]);
         @(negedge ref_clk);
         chk("precode", r, {data_out_a, data_out_b});
      end
      for (i = 0; i < 3; i++) begin
         cfg(1, 0, 0, SRC_INTERNAL, i[1:0], i[2:0], 40'h00_0000_0408, 40'h00_0000_0080,
             40'h00_0000_0080);
         meas(1);
         chk("burst_on", 1600, hi);
         chk("burst_cyc", 3200, per);
         chk("resume", i == 0 ? 0 : (i == 1 ? 52 : 104), (w1 + 129 - w0) % 129);
         if (i == 0) begin
            meas(0);
            chk("trig_hi", 8, hi);
            chk("trig_pos", 2, w0);
         end
      end
      cfg(1, 0, 0, SRC_EXT_TRIGGER, SEQ_RESTART, PAT_BLOCK_SEQ, 40'h00_0000_0408,
          40'h00_0000_0080, 40'h00_0000_0080);
      gwin(0, 200);
      chk("no_gate", 0, c);
      gwin(20, 2500);
      chk("trig_burst", 1600, c);
      cfg(1, 0, 0, SRC_EXT_ENABLE, SEQ_CONTINUOUS, PAT_USER_DATA, 40'h00_0000_0408,
          40'h00_0000_0080, 40'h00_0000_0080);
      gwin(2000, 2500);
      chk("en_burst", 2000, c);
      @(posedge ref_clk) cfg_gating_out_en <= 1'b0;
      cfg(1, 0, 0, SRC_INTERNAL, SEQ_RESTART, 3'h5, 40'h00_0000_0400, 40'h00_0000_0080,
          40'h00_0000_0080);
      gwin(0, 100);
      chk("fallback", 100, c);
      chk("refused", 1, burst_refused);
      summarize();
   end
endmodule

bind psq_sequencer psq_sequencer_asserts u_psq_sequencer_asserts (.ref_clk, .rst, .cfg_apply,
   .cfg_combined, .cfg_burst_mode, .cfg_source, .cfg_burst_seq, .cfg_pattern_kind,
   .cfg_gating_out_en, .cfg_precode_en, .gate_in, .first_data_channel_word, .pat_advance,
   .data_out_a, .data_out_b, .data_valid, .gating_out, .cfg_busy, .burst_refused);

/* File: verilog/psq_pkg.sv */
package psq_pkg;

   // ----------------------------------------------------------------
   // bit counts
   // ----------------------------------------------------------------
   typedef logic [39:0] psq_bits_type;

   localparam psq_bits_type WORD_BITS_1CH = 40'h00_0000_0008;
   localparam psq_bits_type WORD_BITS_2CH = 40'h00_0000_0010;

   // repeat-mode gating pulse: minimum, step and guard against the period
   localparam psq_bits_type GATE_MIN_1CH = 40'h00_0000_0080;
   localparam psq_bits_type GATE_MIN_2CH = 40'h00_0000_0100;
   localparam psq_bits_type GATE_STEP_MASK_1CH = 40'h00_0000_0007;
   localparam psq_bits_type GATE_STEP_MASK_2CH = 40'h00_0000_000F;

   // pattern replication floor and the multiple the period is rounded to
   localparam psq_bits_type REPL_MIN_1CH = 40'h00_0000_0200;
   localparam psq_bits_type REPL_MIN_2CH = 40'h00_0000_0400;
   localparam psq_bits_type LCM_MASK_1CH = 40'h00_0000_007F;
   localparam psq_bits_type LCM_MASK_2CH = 40'h00_0000_00FF;

   // burst timing ranges
   localparam psq_bits_type EP_MIN_1CH = 40'h00_0000_3200;
   localparam psq_bits_type EP_MAX_INT_1CH = 40'h00_7FFF_FF00;
   localparam psq_bits_type EP_MAX_EXT_1CH = 40'h00_8000_0000;
   localparam psq_bits_type CYC_MIN_1CH = 40'h00_0000_6400;
   localparam psq_bits_type CYC_MAX_1CH = 40'h00_8000_0000;
   localparam psq_bits_type BURST_STEP_MASK_1CH = 40'h00_0000_00FF;
   localparam psq_bits_type EP_MIN_2CH = 40'h00_0000_6400;
   localparam psq_bits_type EP_MAX_INT_2CH = 40'h00_FFFF_FE00;
   localparam psq_bits_type EP_MAX_EXT_2CH = 40'h01_0000_0000;
   localparam psq_bits_type CYC_MIN_2CH = 40'h00_0000_C800;
   localparam psq_bits_type CYC_MAX_2CH = 40'h00_FFFF_FC18;
   localparam psq_bits_type BURST_STEP_MASK_2CH = 40'h00_0000_01FF;
   localparam psq_bits_type DISABLE_MIN_1CH = 40'h00_0000_0200;
   localparam psq_bits_type DISABLE_MIN_2CH = 40'h00_0000_0400;

   // burst trigger pulse guard against the burst cycle
   localparam psq_bits_type TRIG_GUARD_1CH = 40'h00_0000_0080;
   localparam psq_bits_type TRIG_GUARD_2CH = 40'h00_0000_0100;

   localparam psq_bits_type BITS_ZERO = 40'h00_0000_0000;
   localparam psq_bits_type BITS_ONE = 40'h00_0000_0001;

   // ----------------------------------------------------------------
   // mode codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_INTERNAL = 2'h0;
   localparam logic [1:0] SRC_EXT_TRIGGER = 2'h1;
   localparam logic [1:0] SRC_EXT_ENABLE = 2'h2;

   localparam logic [1:0] SEQ_RESTART = 2'h0;
   localparam logic [1:0] SEQ_CONSECUTIVE = 2'h1;
   localparam logic [1:0] SEQ_CONTINUOUS = 2'h2;

   localparam logic [2:0] PAT_PRBS = 3'h0;
   localparam logic [2:0] PAT_ZERO_RUN = 3'h1;
   localparam logic [2:0] PAT_USER_DATA = 3'h2;
   localparam logic [2:0] PAT_BLOCK_SEQ = 3'h3;

   localparam logic PRECODE_INIT = 1'h1;

   typedef enum logic [1:0] {
      CALC_IDLE,
      CALC_REPL,
      CALC_CLAMP
   } psq_calc_type;

endpackage

/* File: verilog/psq_sequencer.sv */
module psq_sequencer
   import psq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cfg_apply,
   input wire logic cfg_combined,
   input wire logic cfg_burst_mode,
   input wire logic [1:0] cfg_source,
   input wire logic [1:0] cfg_burst_seq,
   input wire logic [2:0] cfg_pattern_kind,
   input wire logic [39:0] cfg_pattern_len,
   input wire logic [15:0] cfg_row_len,
   input wire logic [15:0] cfg_row_count,
   input wire logic [7:0] cfg_block_count,
   input wire logic [39:0] cfg_gate_width,
   input wire logic [39:0] cfg_gate_delay,
   input wire logic [39:0] cfg_enabled_period,
   input wire logic [39:0] cfg_burst_cycle,
   input wire logic [39:0] cfg_trig_delay,
   input wire logic [39:0] cfg_trig_width,
   input wire logic cfg_gating_out_en,
   input wire logic cfg_precode_en,
   input wire logic precode_init,
   input wire logic gate_in,
   input wire logic [15:0] first_data_channel_word,
   input wire logic [15:0] second_data_channel_word,
   output logic pat_advance,
   output logic pat_rewind,
   output logic [15:0] data_out_a,
   output logic [15:0] data_out_b,
   output logic data_valid,
   output logic gating_out,
   output logic cfg_busy,
   output logic burst_refused
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      psq_calc_type calc;
      logic ready;
      psq_bits_type acc;
      psq_bits_type len;
      psq_bits_type period;
      psq_bits_type gw;
      psq_bits_type gd;
      psq_bits_type ep;
      psq_bits_type cyc;
      psq_bits_type td;
      psq_bits_type tw;
      logic comb;
      logic burst;
      logic refused;
      logic block_pat;
      logic [1:0] src;
      logic [1:0] seq;
      logic gate_en;
      logic pc_en;
      psq_bits_type pos;
      psq_bits_type bcnt;
      psq_bits_type tcnt;
      logic run;
      logic gs1;
      logic gs2;
      logic gs_prev;
      logic pc_i;
      logic pc_q;
      logic [15:0] out_a;
      logic [15:0] out_b;
      logic out_valid;
      logic gate;
   } psq_state_type;

   psq_state_type s_q;
   psq_state_type s_d;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic psq_bits_type clamp_step(input psq_bits_type v, input psq_bits_type lo,
                                               input psq_bits_type hi, input psq_bits_type mask);
      psq_bits_type r;
      r = v & ~mask;
      if (r > (hi & ~mask)) begin
         r = hi & ~mask;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction

   function automatic logic in_window(input psq_bits_type cnt, input psq_bits_type start,
                                      input psq_bits_type width);
      logic [40:0] stop;
      stop = {1'b0, start} + {1'b0, width};
      return (cnt >= start) && ({1'b0, cnt} < stop);
   endfunction

   // differential pre-coding over the word, lsb first, one bit pair per symbol
   function automatic logic [33:0] precode(input logic [15:0] a, input logic [15:0] b,
                                           input logic ip, input logic qp);
      logic [15:0] oa;
      logic [15:0] ob;
      logic i;
      logic q;
      oa = 16'h0000;
      ob = 16'h0000;
      i = ip;
      q = qp;
      for (int k = 0; k < 16; k++) begin
         if (a[k] ^ b[k]) begin
            oa[k] = b[k] ^ q;
            ob[k] = a[k] ^ i;
         end else begin
            oa[k] = a[k] ^ i;
            ob[k] = b[k] ^ q;
         end
         i = oa[k];
         q = ob[k];
      end
      return {i, q, oa, ob};
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   psq_bits_type step;
   psq_bits_type gmin;
   psq_bits_type gmask;
   psq_bits_type bmask;
   psq_bits_type dis_min;
   psq_bits_type guard;
   psq_bits_type next_pos;
   psq_bits_type next_cnt;
   logic start;
   logic en;
   logic adv;
   logic rew;
   logic [15:0] word_a;
   logic [15:0] word_b;
   logic [33:0] pc;

   always_comb begin
      s_d = s_q;
      step = s_q.comb ? WORD_BITS_2CH : WORD_BITS_1CH;
      gmin = s_q.comb ? GATE_MIN_2CH : GATE_MIN_1CH;
      gmask = s_q.comb ? GATE_STEP_MASK_2CH : GATE_STEP_MASK_1CH;
      bmask = s_q.comb ? BURST_STEP_MASK_2CH : BURST_STEP_MASK_1CH;
      dis_min = s_q.comb ? DISABLE_MIN_2CH : DISABLE_MIN_1CH;
      guard = s_q.comb ? TRIG_GUARD_2CH : TRIG_GUARD_1CH;
      next_pos = BITS_ZERO;
      next_cnt = BITS_ZERO;
      start = 1'b0;
      en = 1'b0;
      adv = 1'b0;
      rew = 1'b0;
      word_a = first_data_channel_word;
      word_b = second_data_channel_word;
      pc = precode(word_a, word_b, s_q.pc_i, s_q.pc_q);

      // gate input from the connector: two flops before anything looks at it
      s_d.gs1 = gate_in;
      s_d.gs2 = s_q.gs1;
      s_d.gs_prev = s_q.gs2;

      // settings are taken as one set on apply, save cfg_row_len, cfg_row_count and cfg_block_count, read as replication ends; lengths come from channel one
      case (s_q.calc)
         CALC_IDLE: begin
            if (cfg_apply) begin
               s_d.calc = CALC_REPL;
               s_d.ready = 1'b0;
               s_d.comb = cfg_combined;
               s_d.len = (cfg_pattern_len == BITS_ZERO) ? BITS_ONE : cfg_pattern_len;
               s_d.acc = s_d.len;
               s_d.block_pat = (cfg_pattern_kind == PAT_BLOCK_SEQ);
               s_d.refused = cfg_burst_mode && (cfg_pattern_kind > PAT_BLOCK_SEQ);
               s_d.burst = cfg_burst_mode && !s_d.refused;
               s_d.src = cfg_source;
               s_d.seq = cfg_burst_seq;
               s_d.gate_en = cfg_gating_out_en;
               s_d.pc_en = cfg_precode_en && cfg_combined;
               s_d.gw = cfg_gate_width;
               s_d.gd = cfg_gate_delay;
               s_d.ep = cfg_enabled_period;
               s_d.cyc = cfg_burst_cycle;
               s_d.td = cfg_trig_delay;
               s_d.tw = cfg_trig_width;
            end
         end
         CALC_REPL: begin
            // replicate to the floor, then the replicated unit on to a multiple of 128 (256)
            if (s_q.acc < (s_q.comb ? REPL_MIN_2CH : REPL_MIN_1CH)) begin
               s_d.acc = s_q.acc + s_q.len;
            end else if (s_q.len < (s_q.comb ? REPL_MIN_2CH : REPL_MIN_1CH)) begin
               s_d.len = s_q.acc;
            end else if ((s_q.acc & (s_q.comb ? LCM_MASK_2CH : LCM_MASK_1CH)) != BITS_ZERO) begin
               s_d.acc = s_q.acc + s_q.len;
            end else begin
               s_d.calc = CALC_CLAMP;
               s_d.period = s_q.block_pat ? 40'(cfg_row_len) * 40'(cfg_row_count) *
                            40'(cfg_block_count) : s_q.acc;
            end
         end
         CALC_CLAMP: begin
            s_d.calc = CALC_IDLE;
            s_d.ready = 1'b1;
            s_d.gw = clamp_step(s_q.gw, gmin, s_q.period - gmin, gmask);
            s_d.gd = clamp_step(s_q.gd, gmin, s_q.period - gmin, gmask);
            if (s_q.comb) begin
               s_d.cyc = clamp_step(s_q.cyc, CYC_MIN_2CH, CYC_MAX_2CH, bmask);
               s_d.ep = clamp_step(s_q.ep, EP_MIN_2CH, (s_q.src == SRC_INTERNAL) ?
                                   EP_MAX_INT_2CH : EP_MAX_EXT_2CH, bmask);
            end else begin
               s_d.cyc = clamp_step(s_q.cyc, CYC_MIN_1CH, CYC_MAX_1CH, bmask);
               s_d.ep = clamp_step(s_q.ep, EP_MIN_1CH, (s_q.src == SRC_INTERNAL) ?
                                   EP_MAX_INT_1CH : EP_MAX_EXT_1CH, bmask);
            end
            if (s_q.src == SRC_INTERNAL && s_d.ep > s_d.cyc - dis_min) begin
               s_d.ep = (s_d.cyc - dis_min) & ~bmask;
            end
            s_d.td = clamp_step(s_q.td, BITS_ZERO, s_d.cyc - guard, gmask);
            s_d.tw = clamp_step(s_q.tw, BITS_ZERO, s_d.cyc - guard, gmask);
            s_d.pos = BITS_ZERO;
            s_d.bcnt = BITS_ZERO;
            s_d.tcnt = BITS_ZERO;
            s_d.run = 1'b0;
            s_d.pc_i = PRECODE_INIT;
            s_d.pc_q = PRECODE_INIT;
         end
         default: begin
            s_d.calc = CALC_IDLE;
         end
      endcase

      // --------------------------------------------------------------
      // sequencing, frozen while a new setting set is worked out
      // --------------------------------------------------------------
      if (s_q.ready && s_q.calc == CALC_IDLE) begin
         if (!s_q.burst) begin
            adv = 1'b1;
            en = 1'b1;
            next_pos = s_q.pos + step;
            if (next_pos >= s_q.period) begin
               next_pos = next_pos - s_q.period;
            end
            rew = (s_q.pos == BITS_ZERO); // period holds whole patterns, so only realigns
            s_d.pos = next_pos;
            s_d.gate = in_window(s_q.pos, s_q.gd, s_q.gw) && s_q.gate_en;
         end else begin
            case (s_q.src)
               SRC_INTERNAL: begin
                  start = (s_q.bcnt == BITS_ZERO);
                  en = (s_q.bcnt < s_q.ep);
                  next_cnt = s_q.bcnt + step;
                  s_d.bcnt = (next_cnt >= s_q.cyc) ? BITS_ZERO : next_cnt;
               end
               SRC_EXT_TRIGGER: begin
                  start = s_q.gs2 && !s_q.gs_prev;
                  next_cnt = s_q.tcnt + step;
                  en = start || (s_q.run && next_cnt < s_q.ep);
                  s_d.run = en;
               end
               SRC_EXT_ENABLE: begin
                  start = s_q.gs2 && !s_q.gs_prev;
                  en = s_q.gs2;
               end
               default: begin
                  en = 1'b0;
               end
            endcase
            case (s_q.seq)
               SEQ_RESTART: begin
                  rew = start;
                  adv = en;
               end
               SEQ_CONSECUTIVE: begin
                  adv = en;
               end
               SEQ_CONTINUOUS: begin
                  adv = 1'b1;
               end
               default: begin
                  adv = en;
               end
            endcase
            // trigger counter measures bits from the start of the burst
            next_cnt = start ? BITS_ZERO : s_q.tcnt + step;
            if (!start && next_cnt < s_q.tcnt) begin
               next_cnt = s_q.tcnt; // saturate rather than wrap into a false pulse
            end
            s_d.tcnt = next_cnt;
            s_d.gate = in_window(next_cnt, s_q.td, s_q.tw) && s_q.gate_en;
         end

         if (s_q.pc_en && adv) begin
            word_a = pc[31:16];
            word_b = pc[15:0];
            s_d.pc_i = pc[33];
            s_d.pc_q = pc[32];
         end
      end else begin
         s_d.gate = 1'b0;
      end
      s_d.out_a = en ? word_a : 16'h0000;
      s_d.out_b = en ? word_b : 16'h0000;
      s_d.out_valid = en;

      // a fresh initialise reseeds the pre-coder at any time
      if (precode_init) begin
         s_d.pc_i = PRECODE_INIT;
         s_d.pc_q = PRECODE_INIT;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.pc_i <= PRECODE_INIT;
         s_q.pc_q <= PRECODE_INIT;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pat_advance = adv;
   assign pat_rewind = rew;
   assign data_out_a = s_q.out_a;
   assign data_out_b = s_q.out_b;
   assign data_valid = s_q.out_valid;
   assign gating_out = s_q.gate;
   assign cfg_busy = (s_q.calc != CALC_IDLE);
   assign burst_refused = s_q.refused;

endmodule
